/* File: hw/brc_burst_seq.v */
`timescale 1ns/1ns
`include "brc_defs.vh"
module brc_burst_seq #(
    parameter ADDR_W       = 20,
    parameter DATA_W       = 32,
    parameter HIGH_DENSITY = 0
) (
    // Clock and reset
    input  wire              core_clk,
    input  wire              sys_rst,
    // Power-down request
    input  wire              pd_req,
    // Configuration register port
    input  wire              cfg_wr,
    input  wire [15:0]       cfg_wdata,
    output reg  [15:0]       cfg_rdata,
    // Burst bus pins
    input  wire              burst_clk,
    input  wire              chip_en_n,
    input  wire              addr_latch_n,
    input  wire              burst_adv_n,
    input  wire [ADDR_W-1:0] start_addr,
    output reg               ready_out,
    // Array read port
    output reg  [ADDR_W-1:0] arr_addr,
    input  wire [DATA_W-1:0] arr_data,
    // Output word stream
    output reg  [DATA_W-1:0] dq_data,
    output reg               dq_valid,
    input  wire              dq_ready,
    // Mode status
    output reg               standby,
    output reg               async_mode
);

    localparam ST_IDLE = 3'h1;
    localparam ST_LAT  = 3'h2;
    localparam ST_RUN  = 3'h4;

    reg  [15:0]       cfg_reg;
    reg               k_prev_reg;
    reg               l_prev_reg;
    reg               ltaken_reg;
    reg  [2:0]        state_reg;
    reg  [2:0]        state_next;
    reg  [3:0]        lat_reg;
    reg  [3:0]        lat_next;
    reg  [3:0]        left_reg;
    reg  [3:0]        left_next;
    reg  [1:0]        wait_reg;
    reg  [1:0]        wait_next;
    reg               phase_reg;
    reg               phase_next;
    reg  [ADDR_W-1:0] addr_next;
    reg               ready_next;
    reg               push;
    reg  [DATA_W-1:0] d1_reg;
    reg               v1_reg;

    wire       sync_rd;
    wire       rise_sel;
    wire       act;
    wire       lrel;
    wire       lfall;
    wire       load_now;
    wire [2:0] len_code;
    wire       is_cont;
    wire       is_wrap;
    wire [3:0] lat_val;
    wire [2:0] wmask;
    wire       buf_ok;
    wire       pop;
    wire [ADDR_W-1:0] addr_inc;

    assign sync_rd  = ~cfg_reg[`BRC_B_RSEL];
    // The companion bit is never consulted: the host owns it
    assign rise_sel = (HIGH_DENSITY != 0) ? 1'b1 : cfg_reg[`BRC_B_EDGE];
    assign act      = rise_sel ? (burst_clk & ~k_prev_reg)
                               : (~burst_clk & k_prev_reg);
    assign lrel     = addr_latch_n & ~l_prev_reg;
    assign lfall    = ~addr_latch_n & l_prev_reg;
    // A load on the edge also blocks a second load at release
    assign load_now = sync_rd & ~chip_en_n & ~(ltaken_reg & ~lfall)
                    & ((act & ~addr_latch_n) | lrel);
    assign len_code = cfg_reg[`BRC_F_LEN_HI:`BRC_F_LEN_LO];
    assign is_cont  = (len_code == `BRC_LEN_CONT);
    assign is_wrap  = ~cfg_reg[`BRC_B_WRAP] & ~is_cont;
    assign lat_val  = {1'b0, cfg_reg[`BRC_F_LAT_HI:`BRC_F_LAT_LO]}
                    + `BRC_LAT_OFS;
    assign wmask    = (len_code == `BRC_LEN_8) ? `BRC_MASK_8 : `BRC_MASK_4;
    assign buf_ok   = ~v1_reg;
    assign pop      = dq_valid & dq_ready;
    assign addr_inc = arr_addr + {{(ADDR_W-1){1'b0}}, 1'b1};

    // Configuration register
    always @(posedge core_clk) begin
        if (sys_rst || pd_req) begin
            cfg_reg <= `BRC_CFG_RST;
        end else if (cfg_wr) begin
            cfg_reg <= cfg_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_rdata  <= `BRC_CFG_RST;
            standby    <= 1'b0;
            async_mode <= 1'b1;
        end else begin
            cfg_rdata  <= cfg_reg;
            standby    <= chip_en_n & ~cfg_reg[`BRC_B_STBY];
            async_mode <= cfg_reg[`BRC_B_RSEL];
        end
    end

    // Pin history for edge detection
    always @(posedge core_clk) begin
        if (sys_rst) begin
            k_prev_reg <= 1'b0;
            l_prev_reg <= 1'b1;
            ltaken_reg <= 1'b0;
        end else begin
            k_prev_reg <= burst_clk;
            l_prev_reg <= addr_latch_n;
            if (load_now) begin
                ltaken_reg <= 1'b1;
            end else if (lfall) begin
                ltaken_reg <= 1'b0;
            end
        end
    end

    // Sequencer
    always @* begin
        state_next = state_reg;
        lat_next   = lat_reg;
        left_next  = left_reg;
        wait_next  = wait_reg;
        phase_next = phase_reg;
        addr_next  = arr_addr;
        push       = 1'b0;
        if (load_now) begin
            state_next = ST_LAT;
            addr_next  = start_addr;
            lat_next   = lat_val - 4'h1;
            phase_next = 1'b0;
            left_next  = (len_code == `BRC_LEN_8) ? `BRC_CNT_8 : `BRC_CNT_4;
            wait_next  = 2'h0;
            if (is_cont || cfg_reg[`BRC_B_WRAP]) begin
                case (start_addr[4:0])
                    `BRC_WS_ADDR1: wait_next = `BRC_WS_1;
                    `BRC_WS_ADDR2: wait_next = `BRC_WS_2;
                    `BRC_WS_ADDR3: wait_next = `BRC_WS_3;
                    default:       wait_next = 2'h0;
                endcase
            end
        end else if (chip_en_n || !sync_rd) begin
            state_next = ST_IDLE;
        end else if (act) begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                ST_LAT: begin
                    if (lat_reg <= 4'h1) begin
                        if (buf_ok) begin
                            push       = 1'b1;
                            state_next = ST_RUN;
                        end
                    end else begin
                        lat_next = lat_reg - 4'h1;
                    end
                end
                ST_RUN: begin
                    if (!burst_adv_n && buf_ok) begin
                        if ((wait_reg != 2'h0) &&
                            (arr_addr[4:0] == `BRC_BOUND_LO)) begin
                            wait_next = wait_reg - 2'h1;
                        end else if (cfg_reg[`BRC_B_YLAT] && !phase_reg) begin
                            phase_next = 1'b1;
                        end else begin
                            push       = 1'b1;
                            phase_next = 1'b0;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
        // Every delivered word advances the counter
        if (push) begin
            if (is_wrap) begin
                addr_next = (arr_addr & ~{{(ADDR_W-3){1'b0}}, wmask})
                          | (addr_inc & {{(ADDR_W-3){1'b0}}, wmask});
            end else begin
                addr_next = addr_inc;
            end
            if (!is_cont) begin
                left_next = left_reg - 4'h1;
                if (left_reg == 4'h1) begin
                    state_next = ST_IDLE;
                end
            end
        end
    end

    // Ready drops only on a boundary stall, or one data cycle ahead
    always @* begin
        ready_next = 1'b1;
        if (state_next == ST_RUN && wait_next != 2'h0) begin
            if (addr_next[4:0] == `BRC_BOUND_LO) begin
                ready_next = 1'b0;
            end else if (cfg_reg[`BRC_B_RTIM] &&
                         addr_next[4:0] == `BRC_BOUND_HI) begin
                ready_next = 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            lat_reg   <= 4'h0;
            left_reg  <= 4'h0;
            wait_reg  <= 2'h0;
            phase_reg <= 1'b0;
            arr_addr  <= {ADDR_W{1'b0}};
            ready_out <= 1'b1;
        end else begin
            state_reg <= state_next;
            lat_reg   <= lat_next;
            left_reg  <= left_next;
            wait_reg  <= wait_next;
            phase_reg <= phase_next;
            arr_addr  <= addr_next;
            ready_out <= ready_next;
        end
    end

    // Two-entry buffer; a full buffer stalls the sequencer, so no word is lost
    always @(posedge core_clk) begin
        if (sys_rst) begin
            dq_data  <= {DATA_W{1'b0}};
            dq_valid <= 1'b0;
            d1_reg   <= {DATA_W{1'b0}};
            v1_reg   <= 1'b0;
        end else begin
            case ({push, pop})
                2'h2: begin
                    if (!dq_valid) begin
                        dq_data  <= arr_data;
                        dq_valid <= 1'b1;
                    end else begin
                        d1_reg <= arr_data;
                        v1_reg <= 1'b1;
                    end
                end
                2'h1: begin
                    dq_data  <= d1_reg;
                    dq_valid <= v1_reg;
                    v1_reg   <= 1'b0;
                end
                2'h3: begin
                    if (v1_reg) begin
                        dq_data <= d1_reg;
                        d1_reg  <= arr_data;
                    end else begin
                        dq_data <= arr_data;
                    end
                end
                default: begin
                    dq_valid <= dq_valid;
                end
            endcase
        end
    end

endmodule // brc_burst_seq

/* File: hw/brc_defs.vh */
`ifndef BRC_DEFS_VH
`define BRC_DEFS_VH
`define BRC_CFG_W      16
`define BRC_CFG_RST    16'h8000
`define BRC_B_RSEL     15
`define BRC_B_STBY     14
`define BRC_F_LAT_HI   13
`define BRC_F_LAT_LO   11
`define BRC_B_YLAT     9
`define BRC_B_RTIM     8
`define BRC_B_EDGE     6
`define BRC_B_WRAP     3
`define BRC_F_LEN_HI   2
`define BRC_F_LEN_LO   0
`define BRC_LEN_4      3'h1
`define BRC_LEN_8      3'h2
`define BRC_LEN_CONT   3'h7
`define BRC_LAT_OFS    4'h2
`define BRC_CNT_4      4'h4
`define BRC_CNT_8      4'h8
`define BRC_MASK_4     3'h3
`define BRC_MASK_8     3'h7
`define BRC_WS_ADDR1   5'h1D
`define BRC_WS_ADDR2   5'h1E
`define BRC_WS_ADDR3   5'h1F
`define BRC_WS_1       2'h1
`define BRC_WS_2       2'h2
`define BRC_WS_3       2'h3
`define BRC_BOUND_LO   5'h00
`define BRC_BOUND_HI   5'h1F
`endif

/* File: test/brc_seq_monitor.sv */
`timescale 1ns/1ns
module brc_seq_monitor #(parameter ADDR_W = 20, parameter DATA_W = 32) (
    // Clock and reset
    input wire              core_clk,
    input wire              sys_rst,
    // Config
    input wire              pd_req,
    input wire              cfg_wr,
    input wire [15:0]       cfg_wdata,
    input wire [15:0]       cfg_rdata,
    input wire              async_mode,
    input wire              standby,
    // Burst
    input wire              chip_en_n,
    input wire              ready_out,
    input wire [ADDR_W-1:0] arr_addr,
    input wire [DATA_W-1:0] dq_data,
    input wire              dq_valid,
    input wire              dq_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_rst_defaults: assert property (disable iff (1'b0) sys_rst |=>
        cfg_rdata == 16'h8000 && async_mode && !standby && !dq_valid) else $error("bad reset");
    a_cfg_readback: assert property (cfg_wr && !pd_req ##1 !pd_req |=>
        cfg_rdata == $past(cfg_wdata, 2)) else $error("bad readback");
    a_pd_default: assert property (pd_req |-> ##2 cfg_rdata == 16'h8000)
        else $error("bad power-down");
    a_async_copy: assert property (async_mode == cfg_rdata[15])
        else $error("bad async mode");
    a_standby_rule: assert property (!$past(sys_rst) |->
        standby == ($past(chip_en_n) && !cfg_rdata[14])) else $error("bad standby");
    a_stall_holds: assert property (dq_valid && !dq_ready |=> dq_valid && $stable(dq_data))
        else $error("word lost");
    // Waits only once the config has settled, so a rewrite cannot trip it
    a_wrap_no_wait: assert property ($stable(cfg_rdata) && !cfg_rdata[3] &&
        cfg_rdata[2:0] != 3'h7 |-> ready_out) else $error("wait in wrap burst");
    a_wait_boundary: assert property (!ready_out && !cfg_rdata[8] |->
        arr_addr[4:0] == 5'h00) else $error("wait off boundary");
    // Early timing may pull ready low at the boundary or one word ahead of it
    a_early_ready: assert property (!ready_out && cfg_rdata[8] |->
        arr_addr[4:0] == 5'h00 || arr_addr[4:0] == 5'h1F) else $error("early wait misplaced");
    a_wait_holds: assert property (!ready_out && arr_addr[4:0] == 5'h00 |=>
        $stable(arr_addr)) else $error("counter moved in wait");
endmodule // brc_seq_monitor
bind brc_burst_seq brc_seq_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
    .core_clk(core_clk), .sys_rst(sys_rst), .pd_req(pd_req), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .async_mode(async_mode), .standby(standby),
    .chip_en_n(chip_en_n), .ready_out(ready_out), .arr_addr(arr_addr), .dq_data(dq_data),
    .dq_valid(dq_valid), .dq_ready(dq_ready));

/* File: test/brc_host_model.sv */
`timescale 1ns/1ns
module brc_host_model (
    // Clock and edge choice
    input  wire        core_clk,
    input  wire        edge_rise,
    // Burst bus
    output reg         burst_clk    = 1'b0,
    output reg         chip_en_n    = 1'b1,
    output reg         addr_latch_n = 1'b1,
    output reg         burst_adv_n  = 1'b1,
    output reg  [19:0] start_addr   = 20'h00000
);
    integer n_edges = 0;
    // Burst clock stands still between bursts; a phase lasts two core cycles
    task run(input [19:0] a, input integer n);
        integer i;
        burst_clk = ~edge_rise;
        repeat (2) @(negedge core_clk);
        start_addr = a;
        chip_en_n = 1'b0;
        addr_latch_n = 1'b0;
        burst_adv_n = 1'b0;
        n_edges = 0;
        for (i = 0; i < 2 * n; i = i + 1) begin
            repeat (2) @(negedge core_clk);
            burst_clk = ~burst_clk;
            n_edges = n_edges + (burst_clk == edge_rise);
            if (i == 1) begin
                addr_latch_n = 1'b1;
                start_addr = ~a;
            end
        end
        chip_en_n = 1'b1;
        burst_adv_n = 1'b1;
    endtask
endmodule // brc_host_model

/* File: test/burst_read_config_sequencer_tb.sv */
`timescale 1ns/1ns
module burst_read_config_sequencer_tb;
    reg         core_clk = 1'b0, sys_rst = 1'b1, pd_req = 1'b0, cfg_wr = 1'b0;
    reg         dq_ready = 1'b1, edge_rise = 1'b1, stall = 1'b0;
    reg  [15:0] cfg_wdata = 16'h0000;
    reg  [7:0]  rnd = 8'h16;
    wire [15:0] cfg_rdata;
    wire [19:0] start_addr, arr_addr;
    wire [31:0] dq_data;
    wire        burst_clk, chip_en_n, addr_latch_n, burst_adv_n, ready_out, dq_valid;
    wire        standby, async_mode;
    integer     fail_count = 0, n_compared = 0;
    reg  [31:0] exp_q[$];
    integer     edge_q[$];
    always #5 core_clk = ~core_clk;
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    always @(negedge core_clk) begin
        rnd <= lfsr(rnd);
        dq_ready <= !stall || rnd[0];
    end
    brc_host_model host (.core_clk(core_clk), .edge_rise(edge_rise), .burst_clk(burst_clk),
        .chip_en_n(chip_en_n), .addr_latch_n(addr_latch_n), .burst_adv_n(burst_adv_n),
        .start_addr(start_addr));
    brc_burst_seq dut (.core_clk(core_clk), .sys_rst(sys_rst), .pd_req(pd_req), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .burst_clk(burst_clk), .chip_en_n(chip_en_n),
        .addr_latch_n(addr_latch_n), .burst_adv_n(burst_adv_n), .start_addr(start_addr),
        .ready_out(ready_out), .arr_addr(arr_addr), .arr_data({12'hA5A, arr_addr}),
        .dq_data(dq_data), .dq_valid(dq_valid), .dq_ready(dq_ready), .standby(standby),
        .async_mode(async_mode));
    task chk(input [31:0] e, input [31:0] g, input [39:0] nm);
        n_compared = n_compared + 1;
        if (e !== g) begin
            fail_count = fail_count + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Edge timing is only exact while the receiver never stalls
    always @(posedge core_clk) begin
        if (dq_valid === 1'b1 && dq_ready === 1'b1) begin
            chk(1, exp_q.size() > 0, "extra");
            if (exp_q.size() > 0)
                chk(exp_q.pop_front(), dq_data, "word");
            if (edge_q.size() > 0 && !stall)
                chk(edge_q.pop_front(), host.n_edges, "edge");
        end
    end
    task wcfg(input [15:0] v);
        cfg_wdata = v;
        cfg_wr = 1'b1;
        @(negedge core_clk);
        cfg_wr = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(v, cfg_rdata, "cfg");
        chk(v[15], async_mode, "async");
    endtask
    task burst(input [15:0] c, input [19:0] a, input s);
        integer k, w, nw, m, ad;
        wcfg(c);
        nw = c[15] ? 0 : c[2:0] == 3'h1 ? 4 : c[2:0] == 3'h2 ? 8 : 32;
        m = c[2:0] == 3'h1 ? 3 : 7;
        w = (c[3] || nw == 32) && a[4:0] > 28 ? a[4:0] - 28 : 0;
        for (k = 0; k < nw; k = k + 1) begin
            ad = c[3] || nw == 32 ? a + k : (a & ~m) | ((a + k) & m);
            exp_q.push_back({12'hA5A, ad[19:0]});
            edge_q.push_back(c[13:11] + 2 + k * (c[9] + 1) + (a[4:0] + k > 31 ? w : 0));
        end
        stall = s;
        edge_rise = c[6];
        host.run(a, 36);
        repeat (4) @(negedge core_clk);
        if (nw < 32 && !s)
            chk(0, exp_q.size(), "left");
        chk(!c[14], standby, "stby");
        stall = 1'b0;
        exp_q.delete();
        edge_q.delete();
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        chk(16'h8000, cfg_rdata, "reset");
        // Reserved bits written as zero, companion bit set for sync reads
        burst(16'h88C1, 20'h00002, 0);
        burst(16'h08C1, 20'h00002, 0);
        burst(16'h3282, 20'h00105, 0);
        burst(16'h10C9, 20'h00007, 0);
        burst(16'h18C7, 20'h0001D, 0);
        burst(16'h21CA, 20'h0003E, 0);
        burst(16'h68C7, 20'h0005F, 0);
        burst(16'h08C1, 20'h00013, 1);
        pd_req = 1'b1;
        @(negedge core_clk);
        pd_req = 1'b0;
        @(negedge core_clk);
        chk(16'h8000, cfg_rdata, "pwrdn");
        test_done;
    end
endmodule // burst_read_config_sequencer_tb
